// ===== fkp_defs.svh
// Constants for the flash key, program and erase controller
// Operation
// - Programming only clears bits; only an erase sets them back to one.
// - Erase acts on a whole 512-byte page, leaving all bytes 0xff.
// - Program and erase are timed internally; no polling needed.
// - Core execution is stalled while an operation is in progress.
// - Firmware operations are allowed only after key codes 0xa5 then 0xf1; debug port programs need no key.
// - No timing limit or spacing between the two key writes.
// - Wrong key value or order locks out firmware operations until reset.
// - A firmware operation attempted before unlock also locks out firmware operations.
// - Each firmware operation re-locks when it starts; a fresh unlock is needed.
// - Write enable set redirects data-memory writes to flash.
// - Write enable stays set until software clears it.
// - Erase enable plus write enable erases the whole addressed page.
// - Write enable alone programs exactly the addressed byte.
// - Data-memory reads always go to external RAM; flash read by code reads.
// - Flash programs one byte at a time, by debug port or firmware.
`ifndef FKP_DEFS_SVH
`define FKP_DEFS_SVH
`define FKP_KEY_FIRST 8'ha5
`define FKP_KEY_SECOND 8'hf1
`define FKP_ERASED_BYTE 8'hff
`define FKP_PSC_WE_BIT 0
`define FKP_PSC_EE_BIT 1
`define FKP_PAGE_BYTES 512
`define FKP_PROG_TIME_NS 20000
`define FKP_ERASE_TIME_NS 20000000
`define FKP_CLK_PERIOD_NS 10
`define FKP_PROG_CYCLES ((`FKP_PROG_TIME_NS + `FKP_CLK_PERIOD_NS - 1) / `FKP_CLK_PERIOD_NS)
`define FKP_ERASE_CYCLES ((`FKP_ERASE_TIME_NS + `FKP_CLK_PERIOD_NS - 1) / `FKP_CLK_PERIOD_NS)
`endif

// ===== fkp_pkg.sv
// Types for the flash key, program and erase controller
package fkp_pkg;
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_HALF,
        KEY_OPEN,
        KEY_LOCKED
    } fkp_key_t;
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_PROG,
        OP_ERASE
    } fkp_op_t;
    // Core write request to the data-memory space
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] data;
    } fkp_wr_t;
endpackage

// ===== fkp_timer.sv
// Down counter that times one flash operation
`timescale 1ns/100ps
module fkp_timer #(
    parameter int CW = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [CW-1:0] cycles,
    output logic done
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic run_q;
    logic run_d;
    logic done_d;

    // Load on start, count to one, pulse done
    always_comb
    begin
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        if (start)
        begin
            cnt_d = cycles;
            run_d = 1'b1;
        end
        else if (run_q)
        begin
            if (cnt_q <= {{(CW-1){1'b0}}, 1'b1})
            begin
                run_d = 1'b0;
                done_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Counter registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            done <= done_d;
        end
    end
endmodule

// ===== fkp_ctrl.sv
// Flash key lock, program-write and page-erase sequencer
`timescale 1ns/100ps
`include "fkp_defs.svh"
module fkp_ctrl #(
    parameter int AW = 16,
    parameter int PAGE_BYTES = `FKP_PAGE_BYTES,
    parameter int PROG_CYCLES = `FKP_PROG_CYCLES,
    parameter int ERASE_CYCLES = `FKP_ERASE_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    // Control register write from the core
    input wire logic psc_wr,
    input wire logic [7:0] psc_wdata,
    // Key register write from the core
    input wire logic key_wr,
    input wire logic [7:0] key_wdata,
    // Data-memory write and read from the core
    input wire fkp_pkg::fkp_wr_t dmem_wr,
    input wire logic dmem_rd,
    input wire logic [AW-1:0] dmem_rd_addr,
    // Byte program from the debug port
    input wire fkp_pkg::fkp_wr_t dbg_wr,
    // Control state seen by the core
    output logic program_write_enable,
    output logic page_erase_enable,
    output logic key_locked_out,
    output logic stall,
    // External RAM port
    output logic external_ram_wr,
    output logic external_ram_rd,
    output logic [AW-1:0] external_ram_addr,
    output logic [7:0] external_ram_wdata,
    // Flash array command port
    output logic flash_prog,
    output logic flash_erase,
    output logic [AW-1:0] flash_addr,
    output logic [7:0] flash_wdata
);
    localparam int PW = $clog2(PAGE_BYTES);
    localparam int CW = 32;

    fkp_pkg::fkp_key_t key_q;
    fkp_pkg::fkp_key_t key_d;
    fkp_pkg::fkp_op_t op_q;
    fkp_pkg::fkp_op_t op_d;
    logic we_q;
    logic we_d;
    logic ee_q;
    logic ee_d;
    logic start;
    logic [CW-1:0] cycles;
    logic done;
    logic busy;
    logic redirect;
    logic external_ram_wr_d;
    logic external_ram_rd_d;
    logic [AW-1:0] external_ram_addr_d;
    logic [7:0] external_ram_wdata_d;
    logic fprog_d;
    logic ferase_d;
    logic [AW-1:0] faddr_d;
    logic [7:0] fdata_d;
    logic stall_d;
    logic locked_q;
    logic locked_d;

    // First address of the page holding an address
    function automatic logic [AW-1:0] page_base(input logic [AW-1:0] a);
        page_base = {a[AW-1:PW], {PW{1'b0}}};
    endfunction

    assign busy = (op_q != fkp_pkg::OP_IDLE);
    assign redirect = dmem_wr.valid && we_q;

    // Control bits, key lock and operation state
    always_comb
    begin
        we_d = we_q;
        ee_d = ee_q;
        key_d = key_q;
        op_d = op_q;
        start = 1'b0;
        cycles = CW'(PROG_CYCLES);
        fprog_d = 1'b0;
        ferase_d = 1'b0;
        faddr_d = flash_addr;
        fdata_d = flash_wdata;
        if (psc_wr)
        begin
            we_d = psc_wdata[`FKP_PSC_WE_BIT];
            ee_d = psc_wdata[`FKP_PSC_EE_BIT];
        end
        if (key_wr && key_q != fkp_pkg::KEY_LOCKED)
        begin
            if (key_q == fkp_pkg::KEY_IDLE && key_wdata == `FKP_KEY_FIRST)
                key_d = fkp_pkg::KEY_HALF;
            else if (key_q == fkp_pkg::KEY_HALF && key_wdata == `FKP_KEY_SECOND)
                key_d = fkp_pkg::KEY_OPEN;
            else
                key_d = fkp_pkg::KEY_LOCKED;
        end
        if (done)
        begin
            op_d = fkp_pkg::OP_IDLE;
        end
        if (!busy && redirect && key_q != fkp_pkg::KEY_LOCKED)
        begin
            if (key_q != fkp_pkg::KEY_OPEN)
            begin
                key_d = fkp_pkg::KEY_LOCKED;
            end
            else
            begin
                key_d = fkp_pkg::KEY_IDLE;
                start = 1'b1;
                faddr_d = dmem_wr.addr[AW-1:0];
                fdata_d = dmem_wr.data;
                if (ee_q)
                begin
                    op_d = fkp_pkg::OP_ERASE;
                    cycles = CW'(ERASE_CYCLES);
                    ferase_d = 1'b1;
                    faddr_d = page_base(dmem_wr.addr[AW-1:0]);
                    fdata_d = `FKP_ERASED_BYTE;
                end
                else
                begin
                    op_d = fkp_pkg::OP_PROG;
                    fprog_d = 1'b1;
                end
            end
        end
        else if (!busy && !redirect && dbg_wr.valid)
        begin
            op_d = fkp_pkg::OP_PROG;
            start = 1'b1;
            fprog_d = 1'b1;
            faddr_d = dbg_wr.addr[AW-1:0];
            fdata_d = dbg_wr.data;
        end
        // Lockout flag follows the next key state
        locked_d = (key_d == fkp_pkg::KEY_LOCKED);
    end

    fkp_timer #(
        .CW(CW)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .start(start),
        .cycles(cycles),
        .done(done)
    );

    // External RAM path and stall
    always_comb
    begin
        stall_d = (op_d != fkp_pkg::OP_IDLE);
        external_ram_wr_d = dmem_wr.valid && !we_q;
        external_ram_rd_d = dmem_rd;
        external_ram_addr_d = external_ram_addr;
        external_ram_wdata_d = external_ram_wdata;
        if (dmem_rd)
            external_ram_addr_d = dmem_rd_addr;
        if (external_ram_wr_d)
        begin
            external_ram_addr_d = dmem_wr.addr[AW-1:0];
            external_ram_wdata_d = dmem_wr.data;
        end
    end

    // State registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            key_q <= fkp_pkg::KEY_IDLE;
            op_q <= fkp_pkg::OP_IDLE;
            we_q <= 1'b0;
            ee_q <= 1'b0;
            stall <= 1'b0;
            external_ram_wr <= 1'b0;
            external_ram_rd <= 1'b0;
            external_ram_addr <= '0;
            external_ram_wdata <= 8'h00;
            flash_prog <= 1'b0;
            flash_erase <= 1'b0;
            flash_addr <= '0;
            flash_wdata <= 8'h00;
            locked_q <= 1'b0;
        end
        else
        begin
            key_q <= key_d;
            op_q <= op_d;
            we_q <= we_d;
            ee_q <= ee_d;
            stall <= stall_d;
            external_ram_wr <= external_ram_wr_d;
            external_ram_rd <= external_ram_rd_d;
            external_ram_addr <= external_ram_addr_d;
            external_ram_wdata <= external_ram_wdata_d;
            // Array ANDs programmed data into the cell
            flash_prog <= fprog_d;
            flash_erase <= ferase_d;
            flash_addr <= faddr_d;
            flash_wdata <= fdata_d;
            locked_q <= locked_d;
        end
    end

    assign program_write_enable = we_q;
    assign page_erase_enable = ee_q;
    assign key_locked_out = locked_q;
endmodule

// ===== fkp_ctrl_sva.sv
// Port assertions for the flash key, program and erase controller
`timescale 1ns/100ps
module fkp_ctrl_chk #(
    parameter int AW = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psc_wr,
    input wire fkp_pkg::fkp_wr_t dmem_wr,
    input wire fkp_pkg::fkp_wr_t dbg_wr,
    input wire logic dmem_rd,
    input wire logic program_write_enable,
    input wire logic key_locked_out,
    input wire logic stall,
    input wire logic external_ram_wr,
    input wire logic external_ram_rd,
    input wire logic [AW-1:0] external_ram_addr,
    input wire logic flash_prog,
    input wire logic flash_erase,
    input wire logic [AW-1:0] flash_addr,
    input wire logic [7:0] flash_wdata
);
    // Single clock domain for every property
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_ps; flash_prog |-> stall; endproperty
    a_ps: assert property (p_ps) else $error("prog without stall");
    property p_er; flash_erase |-> flash_wdata == 8'hff && flash_addr[8:0] == 9'h000; endproperty
    a_er: assert property (p_er) else $error("erase not page wide");
    property p_lb;
        key_locked_out && !$past(dbg_wr.valid) |-> !flash_prog && !flash_erase;
    endproperty
    a_lb: assert property (p_lb) else $error("op during lockout");
    property p_ls; key_locked_out |=> key_locked_out; endproperty
    a_ls: assert property (p_ls) else $error("lockout cleared");
    property p_nx; dmem_wr.valid && !stall && program_write_enable |=> !external_ram_wr; endproperty
    a_nx: assert property (p_nx) else $error("flash write hit ram");
    property p_xw;
        dmem_wr.valid && !stall && !program_write_enable |=>
            external_ram_wr && external_ram_addr == $past(dmem_wr.addr);
    endproperty
    a_xw: assert property (p_xw) else $error("ram write lost");
    property p_xr; dmem_rd && !stall |=> external_ram_rd; endproperty
    a_xr: assert property (p_xr) else $error("read not to ram");
    property p_tm; $rose(stall) |-> stall[*3] ##[1:12] !stall; endproperty
    a_tm: assert property (p_tm) else $error("op timing wrong");
    property p_we; $fell(program_write_enable) |-> $past(psc_wr); endproperty
    a_we: assert property (p_we) else $error("enable dropped alone");
endmodule

bind fkp_ctrl fkp_ctrl_chk #(.AW(AW)) i_fkp_ctrl_chk (.clk(clk), .rst(rst), .psc_wr(psc_wr),
    .dmem_wr(dmem_wr), .dbg_wr(dbg_wr), .dmem_rd(dmem_rd),
    .program_write_enable(program_write_enable),
    .key_locked_out(key_locked_out), .stall(stall), .external_ram_wr(external_ram_wr), .external_ram_rd(external_ram_rd),
    .external_ram_addr(external_ram_addr), .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata));

// ===== fkp_flash_model.sv
// Flash array model taking byte program and page erase commands
`timescale 1ns/100ps
module fkp_flash_model (
    input wire logic clk,
    input wire logic flash_prog,
    input wire logic flash_erase,
    input wire logic [15:0] flash_addr,
    input wire logic [7:0] flash_wdata
);
    logic [7:0] mem [int];
    // Unwritten bytes read as erased
    function automatic logic [7:0] rdb(input int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction
    always @(posedge clk)
    begin
        if (flash_prog)
            mem[flash_addr] = rdb(flash_addr) & flash_wdata;
        if (flash_erase)
            for (int i = 0; i < 512; i++)
                mem[{flash_addr[15:9], 9'h000} + i] = 8'hff;
    end
endmodule

// ===== tb.sv
// Self-checking bench for the flash key, program and erase controller
`timescale 1ns/100ps
module tb;
    localparam int PC = 4;
    localparam int EC = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psc_wr = 1'b0;
    logic key_wr = 1'b0;
    logic dmem_rd = 1'b0;
    logic [7:0] psc_wdata = 8'h00;
    logic [7:0] key_wdata = 8'h00;
    logic [15:0] ra = 16'h0000;
    fkp_pkg::fkp_wr_t dmem_wr = '0;
    fkp_pkg::fkp_wr_t dbg_wr = '0;
    logic pwe, pee, lko, stall, xw, xr, fp, fe;
    logic [15:0] xa, fa;
    logic [7:0] xd, fd;
    int bad_count = 0;
    int total_checks = 0;
    fkp_ctrl #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) i_fkp_ctrl (.clk(clk), .rst(rst),
        .psc_wr(psc_wr), .psc_wdata(psc_wdata), .key_wr(key_wr), .key_wdata(key_wdata),
        .dmem_wr(dmem_wr), .dmem_rd(dmem_rd), .dmem_rd_addr(ra), .dbg_wr(dbg_wr),
        .program_write_enable(pwe), .page_erase_enable(pee), .key_locked_out(lko),
        .stall(stall), .external_ram_wr(xw), .external_ram_rd(xr), .external_ram_addr(xa), .external_ram_wdata(xd),
        .flash_prog(fp), .flash_erase(fe), .flash_addr(fa), .flash_wdata(fd));
    fkp_flash_model i_fkp_flash_model (.clk(clk), .flash_prog(fp), .flash_erase(fe),
        .flash_addr(fa), .flash_wdata(fd));
    initial forever #5 clk = ~clk;
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic psc(input logic [7:0] v);
        @(posedge clk) psc_wr <= 1'b1;
        psc_wdata <= v;
        @(posedge clk) psc_wr <= 1'b0;
    endtask
    // Key write, settled state seen at the falling edge
    task automatic key(input logic [7:0] v);
        @(posedge clk) key_wr <= 1'b1;
        key_wdata <= v;
        @(posedge clk) key_wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic unlock();
        key(8'ha5);
        repeat (3) @(posedge clk);
        key(8'hf1);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) dmem_wr <= '{1'b1, a, d};
        @(posedge clk) dmem_wr.valid <= 1'b0;
        @(negedge clk);
    endtask
    // Bounded wait for the operation to end
    task automatic idle(input int mn);
        int n;
        n = 0;
        while (stall === 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk("stall_len", 16'(n), 16'(mn + 1));
    endtask
    task automatic rs();
        @(posedge clk) rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic t_prog();
        psc(8'h01);
        @(posedge clk) dmem_rd <= 1'b1;
        ra <= 16'h0100;
        @(posedge clk) dmem_rd <= 1'b0;
        @(negedge clk);
        chk("external_ram_rd", 16'(xr), 16'h0001);
        chk("external_ram_ra", xa, 16'h0100);
        unlock();
        wr(16'h1234, 8'h3c);
        chk("prog", 16'(fp), 16'h0001);
        chk("addr", fa, 16'h1234);
        chk("data", 16'(fd), 16'h003c);
        chk("stall", 16'(stall), 16'h0001);
        chk("no_external_ram", 16'(xw), 16'h0000);
        idle(PC);
        unlock();
        wr(16'h1234, 8'hf0);
        idle(PC);
        chk("and", 16'(i_fkp_flash_model.rdb(32'h00001234)), 16'h0030);
        chk("we_held", 16'(pwe), 16'h0001);
        $display("test prog done");
    endtask
    task automatic t_erase();
        psc(8'h03);
        @(negedge clk);
        chk("ee", 16'(pee), 16'h0001);
        unlock();
        wr(16'h13a7, 8'h11);
        chk("erase", 16'(fe), 16'h0001);
        chk("page", fa, 16'h1200);
        chk("ff", 16'(fd), 16'h00ff);
        idle(EC);
        chk("erased", 16'(i_fkp_flash_model.rdb(32'h00001234)), 16'h00ff);
        psc(8'h00);
        @(negedge clk);
        chk("ee_clr", 16'(pee), 16'h0000);
        psc(8'h03);
        wr(16'h1200, 8'h00);
        chk("relock", 16'(fe), 16'h0000);
        chk("lock", 16'(lko), 16'h0001);
        unlock();
        wr(16'h1200, 8'h00);
        chk("blocked", 16'(fe | stall), 16'h0000);
        psc(8'h00);
        wr(16'h0042, 8'h5a);
        chk("external_ram_w", 16'(xw), 16'h0001);
        chk("external_ram_a", xa, 16'h0042);
        chk("external_ram_d", 16'(xd), 16'h005a);
        $display("test erase done");
    endtask
    task automatic t_lock();
        rs();
        key(8'hf1);
        chk("order", 16'(lko), 16'h0001);
        rs();
        key(8'ha5);
        key(8'ha6);
        chk("value", 16'(lko), 16'h0001);
        psc(8'h01);
        unlock();
        wr(16'h0200, 8'h00);
        chk("stuck", 16'(fp), 16'h0000);
        rs();
        @(posedge clk) dbg_wr <= '{1'b1, 16'h0300, 8'h77};
        @(posedge clk) dbg_wr.valid <= 1'b0;
        @(negedge clk);
        chk("dbg", 16'(fd), 16'h0077);
        chk("dbg_a", fa, 16'h0300);
        idle(PC);
        $display("test lock done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_prog();
        t_erase();
        t_lock();
        tally_and_finish();
    end
endmodule
